// File: rtl/acm_addr_decoder.sv
// operand address former: fetches operand bytes and pointers, forms the address
// assumes a byte read port on the core clock that answers with ack and data together
//
// How it works
// - seventeen addressing modes are decoded, grouped into seven families.
// - short forms use fewer bytes; all but short indexed and short indirect-indexed keep the address inside page zero.
// - long forms reach all 64 Kbyte at the cost of bytes and cycles.
// - memory-to-memory operations refuse every long addressing form.
// - inherent instructions take no operand bytes at all.
// - immediate takes one byte after the opcode as the operand value.
// - short direct reads one address byte, reaching 00 to FF.
// - long direct reads a two-byte address word.
// - indexed address is the unsigned sum of X or Y and the offset.
// - indexed without offset uses the index alone, no extra byte.
// - short indexed adds one offset byte, reaching up to 1FE.
// - long indexed adds a two-byte offset word to the index.
// - indirect reads a pointer address byte, then the pointer from memory.
// - short indirect uses a byte pointer inside page zero.
// - long indirect forms read a word pointer via one address byte.
// - indirect-indexed adds X or Y to the pointer value read.
// - short indirect-indexed spans 00 to 1FE.
// - relative adds a signed byte offset, direct or read through memory.
// - prefixes 90, 92 and 91 select Y, indirect and Y indirect forms.
module acm_addr_decoder
    import acm_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire logic                  resetn_in,
    input  wire logic                  ce_in,
    input  wire logic                  start_in,
    input  wire logic            [7:0] prefix_in,
    input  wire acm_pkg::acm_mode_type mode_in,
    input  wire logic                  mem_to_mem_in,
    input  wire logic           [15:0] pc_in,
    input  wire logic            [7:0] x_in,
    input  wire logic            [7:0] y_in,
    input  wire logic                  mem_ack_in,
    input  wire logic            [7:0] mem_rdata_in,
    output logic                       busy_out,
    output logic                       done_out,
    output logic                       illegal_out,
    output logic                [15:0] ea_out,
    output logic                [15:0] target_out,
    output logic                 [7:0] operand_out,
    output logic                [15:0] next_pc_out,
    output acm_pkg::acm_mode_type      mode_out,
    output acm_pkg::acm_family_type    family_out,
    output logic                       use_y_out,
    output logic                       mem_rd_out,
    output logic                [15:0] mem_addr_out
);
    import acm_pkg::*;

    acm_state_type  state_q;
    acm_state_type  state_d;
    acm_mode_type   tbl_mode;
    acm_family_type tbl_family;
    logic           tbl_use_y;
    logic     [1:0] tbl_nbytes;
    logic           tbl_ptr_read;
    logic           tbl_ptr_word;
    logic           tbl_long;
    logic           tbl_bad_prefix;
    logic           refuse;
    logic           take;
    logic           ack;
    logic     [1:0] nbytes_q;
    logic           ptr_read_q;
    logic           ptr_word_q;
    logic    [15:0] pc_q;
    logic    [15:0] pc_start_q;
    logic     [7:0] idx_q;
    logic     [7:0] b0_q;
    logic     [7:0] b1_q;
    logic     [7:0] p0_q;
    logic     [7:0] p1_q;
    logic           mm_q;
    logic           long_q;
    logic     [7:0] ptr_addr;
    logic    [15:0] addr_d;
    logic    [15:0] ea_d;
    logic    [15:0] target_d;
    logic    [15:0] rel_base;
    logic     [7:0] rel_off;

    acm_mode_table u_table (
        .prefix_in      (prefix_in),
        .mode_in        (mode_in),
        .mode_out       (tbl_mode),
        .family_out     (tbl_family),
        .use_y_out      (tbl_use_y),
        .nbytes_out     (tbl_nbytes),
        .ptr_read_out   (tbl_ptr_read),
        .ptr_word_out   (tbl_ptr_word),
        .long_out       (tbl_long),
        .bad_prefix_out (tbl_bad_prefix)
    );

    assign take = (state_q == ACM_S_IDLE) && start_in;
    assign ack  = mem_rd_out && mem_ack_in;
    // long forms refused for memory-to-memory work
    assign refuse = tbl_bad_prefix || (mem_to_mem_in && tbl_long);
    // pointer address byte may arrive this cycle, before it is latched
    assign ptr_addr = (state_q == ACM_S_OP0) ? mem_rdata_in : b0_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ACM_S_IDLE: begin
                if (start_in && !refuse) begin
                    state_d = (tbl_nbytes == 2'd0) ? ACM_S_CALC : ACM_S_OP0;
                end
            end
            ACM_S_OP0: begin
                if (ack) begin
                    if (nbytes_q == 2'd2) begin
                        state_d = ACM_S_OP1;
                    end else begin
                        state_d = ptr_read_q ? ACM_S_PTR0 : ACM_S_CALC;
                    end
                end
            end
            ACM_S_OP1: begin
                if (ack) begin
                    state_d = ptr_read_q ? ACM_S_PTR0 : ACM_S_CALC;
                end
            end
            // pointer read after the pointer address byte
            ACM_S_PTR0: begin
                if (ack) begin
                    state_d = ptr_word_q ? ACM_S_PTR1 : ACM_S_CALC;
                end
            end
            ACM_S_PTR1: begin
                if (ack) begin
                    state_d = ACM_S_CALC;
                end
            end
            ACM_S_CALC: state_d = ACM_S_IDLE;
            default:    state_d = ACM_S_IDLE;
        endcase
    end

    always_comb begin
        addr_d = mem_addr_out;
        case (state_d)
            ACM_S_OP0:  addr_d = take ? pc_in : pc_q;
            // pc_q has already stepped once op0 is taken, so hold the address while stalled
            ACM_S_OP1:  addr_d = (state_q == ACM_S_OP0) ? pc_q + ACM_ADDR_STEP : mem_addr_out;
            // pointer address lies in page zero
            ACM_S_PTR0: addr_d = {ACM_PAGE_ZERO_HI, ptr_addr};
            ACM_S_PTR1: addr_d = {ACM_PAGE_ZERO_HI, b0_q} + ACM_ADDR_STEP;
            default:    addr_d = mem_addr_out;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state_q  <= ACM_S_IDLE;
            busy_out <= 1'b0;
        end else if (ce_in) begin
            state_q  <= state_d;
            busy_out <= (state_d != ACM_S_IDLE);
        end
    end

    // read request holds its address until acknowledged
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            mem_rd_out   <= 1'b0;
            mem_addr_out <= ACM_ADDR_RESET;
        end else if (ce_in) begin
            mem_rd_out   <= state_d inside {ACM_S_OP0, ACM_S_OP1, ACM_S_PTR0, ACM_S_PTR1};
            mem_addr_out <= addr_d;
        end
    end

    // per-instruction context, caught when the request is taken
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            nbytes_q   <= ACM_LEN_RESET;
            ptr_read_q <= 1'b0;
            ptr_word_q <= 1'b0;
            mm_q       <= 1'b0;
            long_q     <= 1'b0;
            idx_q      <= ACM_BYTE_RESET;
            pc_start_q <= ACM_ADDR_RESET;
            mode_out   <= ACM_INH;
            family_out <= ACM_FAM_INHERENT;
            use_y_out  <= 1'b0;
        end else if (ce_in && take) begin
            nbytes_q   <= tbl_nbytes;
            ptr_read_q <= tbl_ptr_read;
            ptr_word_q <= tbl_ptr_word;
            mm_q       <= mem_to_mem_in;
            long_q     <= tbl_long;
            // index register chosen by the prefix
            idx_q      <= tbl_use_y ? y_in : x_in;
            pc_start_q <= pc_in;
            mode_out   <= tbl_mode;
            family_out <= tbl_family;
            use_y_out  <= tbl_use_y;
        end
    end

    // operand and pointer bytes, in fetch order
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            pc_q <= ACM_ADDR_RESET;
            b0_q <= ACM_BYTE_RESET;
            b1_q <= ACM_BYTE_RESET;
            p0_q <= ACM_BYTE_RESET;
            p1_q <= ACM_BYTE_RESET;
        end else if (ce_in) begin
            if (take) begin
                pc_q <= pc_in;
            end else if (ack && (state_q inside {ACM_S_OP0, ACM_S_OP1})) begin
                pc_q <= pc_q + ACM_ADDR_STEP;
            end
            if (ack && state_q == ACM_S_OP0) begin
                b0_q <= mem_rdata_in;
            end
            if (ack && state_q == ACM_S_OP1) begin
                b1_q <= mem_rdata_in;
            end
            if (ack && state_q == ACM_S_PTR0) begin
                p0_q <= mem_rdata_in;
            end
            if (ack && state_q == ACM_S_PTR1) begin
                p1_q <= mem_rdata_in;
            end
        end
    end

    assign rel_base = pc_q;
    assign rel_off  = (mode_out == ACM_REL_I) ? p0_q :
                      (mode_out == ACM_REL_D) ? b0_q : b1_q;

    always_comb begin
        ea_d = ACM_ADDR_RESET;
        // signed offset added to the pc after the operand bytes
        target_d = rel_base + {{8{rel_off[7]}}, rel_off};
        case (mode_out)
            ACM_DIR_S,
            ACM_BIT_D,
            ACM_BITREL_D: ea_d = {ACM_PAGE_ZERO_HI, b0_q};
            ACM_DIR_L:    ea_d = {b0_q, b1_q};
            ACM_IDX_0:    ea_d = {ACM_PAGE_ZERO_HI, idx_q};
            ACM_IDX_S:    ea_d = {ACM_PAGE_ZERO_HI, b0_q} + {ACM_PAGE_ZERO_HI, idx_q};
            // word offset plus index, wraps at 64 Kbyte
            ACM_IDX_L:    ea_d = {b0_q, b1_q} + {ACM_PAGE_ZERO_HI, idx_q};
            // byte pointer stays in page zero
            ACM_IND_S,
            ACM_BIT_I,
            ACM_BITREL_I: ea_d = {ACM_PAGE_ZERO_HI, p0_q};
            ACM_IND_L:    ea_d = {p0_q, p1_q};
            ACM_INDIDX_S: ea_d = {ACM_PAGE_ZERO_HI, p0_q} + {ACM_PAGE_ZERO_HI, idx_q};
            ACM_INDIDX_L: ea_d = {p0_q, p1_q} + {ACM_PAGE_ZERO_HI, idx_q};
            default:      ea_d = ACM_ADDR_RESET;
        endcase
    end

    // results appear together with the done pulse
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            done_out    <= 1'b0;
            illegal_out <= 1'b0;
            ea_out      <= ACM_ADDR_RESET;
            target_out  <= ACM_ADDR_RESET;
            operand_out <= ACM_BYTE_RESET;
            next_pc_out <= ACM_ADDR_RESET;
        end else if (ce_in) begin
            done_out <= 1'b0;
            if (take && refuse) begin
                done_out    <= 1'b1;
                illegal_out <= 1'b1;
                next_pc_out <= pc_in;
            end else if (state_q == ACM_S_CALC) begin
                done_out    <= 1'b1;
                illegal_out <= 1'b0;
                ea_out      <= ea_d;
                target_out  <= target_d;
                // immediate byte used as the value
                operand_out <= b0_q;
                next_pc_out <= pc_q;
            end
        end
    end

    chk_long_dir_order: assert property (@(posedge clk_in) disable iff (!resetn_in)
        done_out && !illegal_out && mode_out == ACM_DIR_L |-> ea_out == {b0_q, b1_q})
        else $error("long direct address not high byte first");
    // short direct, indirect, bit and zero-offset indexed forms stay in page zero
    chk_short_page: assert property (@(posedge clk_in) disable iff (!resetn_in)
        done_out && !illegal_out && mode_out inside {ACM_DIR_S, ACM_IDX_0, ACM_IND_S,
            ACM_BIT_D, ACM_BIT_I} |-> ea_out[15:8] == ACM_PAGE_ZERO_HI)
        else $error("short address left page zero");
    chk_short_idx_reach: assert property (@(posedge clk_in) disable iff (!resetn_in)
        done_out && !illegal_out && mode_out inside {ACM_IDX_S, ACM_INDIDX_S}
        |-> ea_out <= ACM_SHORT_IDX_MAX && ea_out >= {ACM_PAGE_ZERO_HI, idx_q})
        else $error("short indexed address out of reach");
    chk_mm_long_refuse: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && take && mem_to_mem_in && tbl_long |=> done_out && illegal_out && !busy_out)
        else $error("long form accepted for memory to memory");
    // operand byte count matches the mode
    chk_length_count: assert property (@(posedge clk_in) disable iff (!resetn_in)
        done_out && !illegal_out |-> next_pc_out == pc_start_q + {14'h0000, nbytes_q})
        else $error("operand byte count wrong");
    chk_read_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
        mem_rd_out && !(mem_ack_in && ce_in) |=> mem_rd_out && $stable(mem_addr_out))
        else $error("read request dropped before ack");
    chk_ptr_page: assert property (@(posedge clk_in) disable iff (!resetn_in)
        state_q == ACM_S_PTR0 && mem_rd_out |-> mem_addr_out == {ACM_PAGE_ZERO_HI, b0_q})
        else $error("pointer read outside page zero");
    chk_rel_target: assert property (@(posedge clk_in) disable iff (!resetn_in)
        done_out && !illegal_out && mode_out == ACM_REL_D
        |-> target_out == next_pc_out + {{8{b0_q[7]}}, b0_q})
        else $error("relative target wrong");
    chk_long_ind_ptr: assert property (@(posedge clk_in) disable iff (!resetn_in)
        done_out && !illegal_out && mode_out == ACM_IND_L |-> ea_out == {p0_q, p1_q})
        else $error("long indirect pointer wrong");
    chk_y_prefix: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && take && !refuse && prefix_in == ACM_Y_INDEX_PREFIX
        |=> use_y_out && idx_q == $past(y_in))
        else $error("y prefix did not select y");
    // one-cycle done pulse
    chk_done_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in)
        done_out && ce_in && state_q == ACM_S_IDLE && !start_in |=> !done_out)
        else $error("done held longer than one cycle");
endmodule

// File: include/acm_pkg.sv
// package for the operand addressing decoder: mode codes, states, prefix codes
// assumes a single core clock and a byte-wide program/data memory read port
package acm_pkg;

    // seventeen operand addressing modes; base codes are the x-based, direct forms
    typedef enum logic [4:0] {
        ACM_INH      = 5'h00,
        ACM_IMM      = 5'h01,
        ACM_DIR_S    = 5'h02,
        ACM_DIR_L    = 5'h03,
        ACM_IDX_0    = 5'h04,
        ACM_IDX_S    = 5'h05,
        ACM_IDX_L    = 5'h06,
        ACM_IND_S    = 5'h07,
        ACM_IND_L    = 5'h08,
        ACM_INDIDX_S = 5'h09,
        ACM_INDIDX_L = 5'h0A,
        ACM_REL_D    = 5'h0B,
        ACM_REL_I    = 5'h0C,
        ACM_BIT_D    = 5'h0D,
        ACM_BIT_I    = 5'h0E,
        ACM_BITREL_D = 5'h0F,
        ACM_BITREL_I = 5'h10
    } acm_mode_type;

    // seven mode families
    typedef enum logic [2:0] {
        ACM_FAM_INHERENT  = 3'h0,
        ACM_FAM_IMMEDIATE = 3'h1,
        ACM_FAM_DIRECT    = 3'h2,
        ACM_FAM_INDEXED   = 3'h3,
        ACM_FAM_INDIRECT  = 3'h4,
        ACM_FAM_RELATIVE  = 3'h5,
        ACM_FAM_BIT       = 3'h6
    } acm_family_type;

    typedef enum logic [2:0] {
        ACM_S_IDLE = 3'h0,
        ACM_S_OP0  = 3'h1,
        ACM_S_OP1  = 3'h2,
        ACM_S_PTR0 = 3'h3,
        ACM_S_PTR1 = 3'h4,
        ACM_S_CALC = 3'h5
    } acm_state_type;

    localparam logic [7:0]  ACM_NO_PREFIX         = 8'h00;
    localparam logic [7:0]  ACM_Y_INDEX_PREFIX    = 8'h90;
    localparam logic [7:0]  ACM_Y_INDIRECT_PREFIX = 8'h91;
    localparam logic [7:0]  ACM_INDIRECT_PREFIX   = 8'h92;
    localparam logic [7:0]  ACM_PAGE_ZERO_HI      = 8'h00;
    localparam logic [15:0] ACM_SHORT_IDX_MAX     = 16'h01FE;
    localparam logic [15:0] ACM_ADDR_RESET        = 16'h0000;
    localparam logic [7:0]  ACM_BYTE_RESET        = 8'h00;
    localparam logic [15:0] ACM_ADDR_STEP         = 16'h0001;
    localparam logic [1:0]  ACM_LEN_RESET         = 2'h0;

endpackage

// File: rtl/acm_mode_table.sv
// mode table: applies a prefix byte to a base mode and gives its attributes
// purely combinational; the caller registers whatever it keeps
module acm_mode_table
    import acm_pkg::*;
(
    input  wire logic           [7:0] prefix_in,
    input  wire acm_pkg::acm_mode_type mode_in,
    output acm_pkg::acm_mode_type     mode_out,
    output acm_pkg::acm_family_type   family_out,
    output logic                      use_y_out,
    output logic                [1:0] nbytes_out,
    output logic                      ptr_read_out,
    output logic                      ptr_word_out,
    output logic                      long_out,
    output logic                      bad_prefix_out
);
    always_comb begin
        mode_out       = mode_in;
        use_y_out      = 1'b0;
        bad_prefix_out = 1'b0;
        case (prefix_in)
            ACM_NO_PREFIX: begin
            end
            ACM_Y_INDEX_PREFIX: begin
                use_y_out = 1'b1;
                bad_prefix_out = !(mode_in inside {ACM_INH, ACM_IMM, ACM_DIR_S, ACM_DIR_L,
                                                   ACM_IDX_0, ACM_IDX_S, ACM_IDX_L});
            end
            ACM_INDIRECT_PREFIX: begin
                case (mode_in)
                    ACM_DIR_S:    mode_out = ACM_IND_S;
                    ACM_DIR_L:    mode_out = ACM_IND_L;
                    ACM_IDX_S:    mode_out = ACM_INDIDX_S;
                    ACM_IDX_L:    mode_out = ACM_INDIDX_L;
                    ACM_REL_D:    mode_out = ACM_REL_I;
                    ACM_BIT_D:    mode_out = ACM_BIT_I;
                    ACM_BITREL_D: mode_out = ACM_BITREL_I;
                    default:      bad_prefix_out = 1'b1;
                endcase
            end
            ACM_Y_INDIRECT_PREFIX: begin
                // the y indirect prefix reaches only the indirect-indexed forms, indexed by y
                case (mode_in)
                    ACM_IDX_S: mode_out = ACM_INDIDX_S;
                    ACM_IDX_L: mode_out = ACM_INDIDX_L;
                    default:   bad_prefix_out = 1'b1;
                endcase
                use_y_out = 1'b1;
            end
            default: bad_prefix_out = 1'b1;
        endcase
    end

    always_comb begin
        family_out   = ACM_FAM_INHERENT;
        nbytes_out   = 2'd0;
        ptr_read_out = 1'b0;
        ptr_word_out = 1'b0;
        long_out     = 1'b0;
        case (mode_out)
            ACM_INH:      family_out = ACM_FAM_INHERENT;
            ACM_IMM:      begin family_out = ACM_FAM_IMMEDIATE; nbytes_out = 2'd1; end
            ACM_DIR_S:    begin family_out = ACM_FAM_DIRECT; nbytes_out = 2'd1; end
            ACM_DIR_L:    begin family_out = ACM_FAM_DIRECT; nbytes_out = 2'd2;
                                long_out = 1'b1; end
            // indexed offsets of 0, 1 or 2 bytes
            ACM_IDX_0:    family_out = ACM_FAM_INDEXED;
            ACM_IDX_S:    begin family_out = ACM_FAM_INDEXED; nbytes_out = 2'd1; end
            ACM_IDX_L:    begin family_out = ACM_FAM_INDEXED; nbytes_out = 2'd2;
                                long_out = 1'b1; end
            // one pointer address byte, byte or word pointer
            ACM_IND_S,
            ACM_INDIDX_S: begin family_out = ACM_FAM_INDIRECT; nbytes_out = 2'd1;
                                ptr_read_out = 1'b1; end
            ACM_IND_L,
            ACM_INDIDX_L: begin family_out = ACM_FAM_INDIRECT; nbytes_out = 2'd1;
                                ptr_read_out = 1'b1; ptr_word_out = 1'b1;
                                long_out = 1'b1; end
            ACM_REL_D:    begin family_out = ACM_FAM_RELATIVE; nbytes_out = 2'd1; end
            ACM_REL_I:    begin family_out = ACM_FAM_RELATIVE; nbytes_out = 2'd1;
                                ptr_read_out = 1'b1; end
            ACM_BIT_D:    begin family_out = ACM_FAM_BIT; nbytes_out = 2'd1; end
            ACM_BIT_I:    begin family_out = ACM_FAM_BIT; nbytes_out = 2'd1;
                                ptr_read_out = 1'b1; end
            ACM_BITREL_D: begin family_out = ACM_FAM_BIT; nbytes_out = 2'd2; end
            ACM_BITREL_I: begin family_out = ACM_FAM_BIT; nbytes_out = 2'd2;
                                ptr_read_out = 1'b1; end
            default:      family_out = ACM_FAM_INHERENT;
        endcase
    end
endmodule

// File: verif/acm_mem_model.sv
// byte memory model for the operand address former, stalling at random
// assumes the requester holds read and address until ack is seen high
module acm_mem_model (
    input  wire logic        clk_in,
    input  wire logic        rd_in,
    input  wire logic [15:0] addr_in,
    output logic             ack_out,
    output logic       [7:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] stall_q = 32'h0000_0cb4;
    logic  [7:0] last_q  = 8'h00;
    assign ack_out = rd_in && !(stall_q[1] && stall_q[0]);
    // idle data is inverted so a stale byte never passes for an answer
    assign rdata_out = ack_out ? (addr_in[7:0] ^ addr_in[15:8] ^ 8'h3c) : ~last_q;
    always_ff @(posedge clk_in) begin
        stall_q <= {stall_q[30:0], stall_q[31] ^ stall_q[21] ^ stall_q[1] ^ stall_q[0]};
        last_q  <= rdata_out;
    end
endmodule

// File: verif/test_acm_addr_decoder.sv
// self-checking bench for the operand address former
// assumes the memory model answers every read after a random stall
module test_acm_addr_decoder;
    import acm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, resetn = 1'b0, ce = 1'b0, start = 1'b0, m2m = 1'b0;
    logic [7:0]  pfx = 8'h00, x = 8'h00, y = 8'h00, rdata, op_o;
    logic [15:0] pc = 16'h0000, ea, tgt, npc, maddr;
    logic        busy, done, ill, ack, rd, uy_o, done_q = 1'b0;
    logic [31:0] seed = 32'h0000_0cb4;
    logic [67:0] e, exp_q[$];
    acm_mode_type mode = ACM_INH, mode_o;
    acm_family_type fam_o;
    int n_errors = 0, samples_checked = 0;
    always #2.5 clk = ~clk;
    acm_addr_decoder u_acm_addr_decoder (.clk_in(clk), .resetn_in(resetn), .ce_in(ce),
        .start_in(start), .prefix_in(pfx), .mode_in(mode), .mem_to_mem_in(m2m), .pc_in(pc),
        .x_in(x), .y_in(y), .mem_ack_in(ack), .mem_rdata_in(rdata), .busy_out(busy),
        .done_out(done), .illegal_out(ill), .ea_out(ea), .target_out(tgt), .operand_out(op_o),
        .next_pc_out(npc), .mode_out(mode_o), .family_out(fam_o), .use_y_out(uy_o),
        .mem_rd_out(rd), .mem_addr_out(maddr));
    acm_mem_model u_acm_mem_model (.clk_in(clk), .rd_in(rd), .addr_in(maddr),
        .ack_out(ack), .rdata_out(rdata));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] mb(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    function automatic logic [15:0] sx(input logic [7:0] b);
        return {{8{b[7]}}, b};
    endfunction
    function automatic logic [67:0] predict(input acm_mode_type md, input logic uy,
                                            input logic bad);
        logic [15:0] p, w, lw, pv, idx, ea_e, t_e;
        logic [1:0]  n;
        logic        ct;
        acm_family_type fm;
        p = {8'h00, mb(pc)};
        lw = {p[7:0], mb(pc + 16'h0001)};
        pv = {8'h00, mb(p)};
        w = {pv[7:0], mb(p + 16'h0001)};
        idx = {8'h00, uy ? y : x};
        ea_e = 16'h0000;
        t_e = 16'h0000;
        n = 2'h1;
        ct = md inside {ACM_REL_D, ACM_REL_I, ACM_BITREL_D, ACM_BITREL_I};
        fm = (md == ACM_INH) ? ACM_FAM_INHERENT : (md == ACM_IMM) ? ACM_FAM_IMMEDIATE :
             (md inside {ACM_DIR_S, ACM_DIR_L}) ? ACM_FAM_DIRECT :
             (md inside {ACM_IDX_0, ACM_IDX_S, ACM_IDX_L}) ? ACM_FAM_INDEXED :
             (md inside {ACM_REL_D, ACM_REL_I}) ? ACM_FAM_RELATIVE :
             (md inside {ACM_BIT_D, ACM_BIT_I, ACM_BITREL_D, ACM_BITREL_I}) ? ACM_FAM_BIT :
             ACM_FAM_INDIRECT;
        case (md)
            ACM_INH:              n = 2'h0;
            ACM_IDX_0: begin n = 2'h0; ea_e = idx; end
            ACM_DIR_S, ACM_BIT_D: ea_e = p;
            ACM_DIR_L: begin n = 2'h2; ea_e = lw; end
            ACM_IDX_S:            ea_e = idx + p;
            ACM_IDX_L: begin n = 2'h2; ea_e = idx + lw; end
            ACM_IND_S, ACM_BIT_I: ea_e = pv;
            ACM_IND_L:            ea_e = w;
            ACM_INDIDX_S:         ea_e = idx + pv;
            ACM_INDIDX_L:         ea_e = idx + w;
            ACM_REL_D:            t_e = pc + 16'h0001 + sx(p[7:0]);
            ACM_REL_I:            t_e = pc + 16'h0001 + sx(pv[7:0]);
            ACM_BITREL_D: begin n = 2'h2; ea_e = p; t_e = pc + 16'h0002 + sx(lw[7:0]); end
            ACM_BITREL_I: begin n = 2'h2; ea_e = pv; t_e = pc + 16'h0002 + sx(lw[7:0]); end
            default: ;
        endcase
        if (bad) n = 2'h0;
        return {fm, uy, p[7:0], ct & !bad, !bad, bad, md, ea_e, pc + {14'h0000, n}, t_e};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        $display("errors %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic req(input logic [7:0] pf, input acm_mode_type md, input acm_mode_type eff,
                       input logic uy, input logic bad, input logic mm);
        seed = lfsr(seed);
        {y, x, pc} = seed;
        pfx = pf;
        mode = md;
        m2m = mm;
        ce = 1'b1;
        start = 1'b1;
        exp_q.push_back(predict(eff, uy, bad));
        @(posedge clk);
        #1 start = 1'b0;
        for (int k = 0; k < 200 && busy; k++) begin
            seed = lfsr(seed);
            ce = |seed[2:0];
            @(posedge clk);
            #1;
        end
        ce = 1'b1;
        // one idle edge so start is never lowered and raised in one time step
        @(posedge clk);
        #1;
    endtask
    always @(posedge clk) begin
        done_q <= done;
        if (done && !done_q) begin
            e = exp_q.pop_front();
            chk({15'h0000, ill}, {15'h0000, e[53]});
            chk(npc, e[31:16]);
            if (e[54]) chk({11'h000, mode_o}, {11'h000, e[52:48]});
            if (e[54]) chk(ea, e[47:32]);
            if (e[55]) chk(tgt, e[15:0]);
            if (e[54]) chk({13'h0000, fam_o}, {13'h0000, e[67:65]});
            if (e[54]) chk({15'h0000, uy_o}, {15'h0000, e[64]});
            if (e[54] && e[52:48] == ACM_IMM) chk({8'h00, op_o}, {8'h00, e[63:56]});
        end
    end
    initial begin
        acm_mode_type md_i;
        repeat (16) @(posedge clk);
        #1 resetn = 1'b1;
        for (int i = 0; i < 68; i++) begin
            md_i = acm_mode_type'(i % 17);
            req(8'h00, md_i, md_i, 1'b0,
                i[0] && (md_i inside {ACM_DIR_L, ACM_IDX_L, ACM_IND_L, ACM_INDIDX_L}), i[0]);
        end
        req(8'h90, ACM_IDX_0, ACM_IDX_0, 1'b1, 1'b0, 1'b0);
        req(8'h90, ACM_IDX_L, ACM_IDX_L, 1'b1, 1'b0, 1'b0);
        req(8'h92, ACM_DIR_S, ACM_IND_S, 1'b0, 1'b0, 1'b0);
        req(8'h92, ACM_IDX_L, ACM_INDIDX_L, 1'b0, 1'b0, 1'b0);
        req(8'h92, ACM_REL_D, ACM_REL_I, 1'b0, 1'b0, 1'b0);
        req(8'h92, ACM_BITREL_D, ACM_BITREL_I, 1'b0, 1'b0, 1'b0);
        req(8'h91, ACM_IDX_S, ACM_INDIDX_S, 1'b1, 1'b0, 1'b0);
        req(8'h91, ACM_INH, ACM_INH, 1'b0, 1'b1, 1'b0);
        req(8'h55, ACM_IMM, ACM_IMM, 1'b0, 1'b1, 1'b0);
        req(8'h00, ACM_DIR_L, ACM_DIR_L, 1'b0, 1'b1, 1'b1);
        req(8'h00, ACM_INDIDX_L, ACM_INDIDX_L, 1'b0, 1'b1, 1'b1);
        repeat (4) @(posedge clk);
        chk(16'(exp_q.size()), 16'h0000);
        tally_and_finish();
    end
    initial begin
        #100000;
        n_errors++;
        tally_and_finish();
    end
endmodule
